// File: core/pdc_pkg.sv
// constants, register map and field layout for the pll divider configuration
// Operation
// - config bits 30:29 pick one of four oscillator phases for primary global
// - bits 28:24 divide second secondary outputs by field plus one
// - bits 23:19 divide first secondary outputs by field plus one
// - bits 18:14 divide primary global output by field plus one
// - bits 13:7 set feedback ratio m as field plus one, max 128
// - bits 6:0 divide reference input by field plus one before loop
// - primary frequency equals reference times m over n times u
// - secondary pairs run at reference times m over n and own divider
package pdc_pkg;

    // register bus
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  CONFIG_OFFSET   = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
    localparam logic [31:0] CONFIG_RESET    = 32'h0000_0000;

    // configuration word field positions
    localparam int PHASE_SEL_MSB  = 31;
    localparam int PHASE_SEL_LSB  = 29;
    localparam int SEC2_DIV_MSB   = 28;
    localparam int SEC2_DIV_LSB   = 24;
    localparam int SEC1_DIV_MSB   = 23;
    localparam int SEC1_DIV_LSB   = 19;
    localparam int PRIM_DIV_MSB   = 18;
    localparam int PRIM_DIV_LSB   = 14;
    localparam int FB_DIV_MSB     = 13;
    localparam int FB_DIV_LSB     = 7;
    localparam int IN_DIV_MSB     = 6;
    localparam int IN_DIV_LSB     = 0;

    // status word layout
    localparam int STATUS_LOCK_BIT = 31;

    // loop model widths
    localparam int OUT_DIV_W   = 5;
    localparam int LOOP_DIV_W  = 7;
    localparam int PERIOD_W    = 16;
    localparam int ACC_W       = 18;
    localparam int PHASE_COUNT = 4;

    // measurements needed before the oscillator runs
    localparam logic [1:0] LOCK_MEASURES = 2'h2;

    typedef enum logic [1:0] {
        PDC_HUNT,
        PDC_MEASURE,
        PDC_RUN
    } pdc_loop_state_t;

endpackage : pdc_pkg

// File: core/pdc_out_div.sv
// output divider: turns oscillator edges into a divided clock level
module pdc_out_div (
    // clock and reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          reset_i,
    // oscillator phase
    input  wire logic                          edge_i,
    input  wire logic                          level_i,
    // divider field, ratio is field plus one
    input  wire logic [pdc_pkg::OUT_DIV_W-1:0] ratio_i,
    // divided clock
    output logic                               clk_o
);

    logic [pdc_pkg::OUT_DIV_W-1:0] ratio_reg;
    logic [pdc_pkg::OUT_DIV_W-1:0] cnt_reg;
    logic                          clk_reg;

    // a new ratio is adopted only when a full output period ends
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ratio_reg <= '0;
            cnt_reg   <= '0;
        end else if (edge_i) begin
            if (cnt_reg == ratio_reg) begin
                cnt_reg   <= '0;
                ratio_reg <= ratio_i;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // high for the first half of the period, longer half for odd ratios
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            clk_reg <= 1'b0;
        end else if (ratio_reg == '0) begin
            clk_reg <= level_i;
        end else begin
            clk_reg <= (cnt_reg <= (ratio_reg >> 1));
        end
    end

    assign clk_o = clk_reg;

endmodule : pdc_out_div

// File: core/pdc_pll_divider_config.sv
// clock conditioner: digital loop model with input, feedback and output dividers
//
// Design decisions made here: strobed register access and the placing of the registers.
module pdc_pll_divider_config (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        reset_i,
    // reference clock from pad or core routing
    input  wire logic                        reference_clock_in_i,
    // register port
    input  wire logic [pdc_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [31:0]                 reg_wdata_i,
    input  wire logic                        reg_write_i,
    input  wire logic                        reg_read_i,
    output logic      [31:0]                 reg_rdata_o,
    // conditioned clocks
    output logic                             primary_global_clock_o,
    output logic                             first_secondary_global_clock_o,
    output logic                             first_secondary_core_clock_o,
    output logic                             second_secondary_global_clock_o,
    output logic                             second_secondary_core_clock_o,
    // loop status
    output logic                             loop_locked_o
);

    logic [31:0]                    config_reg;
    logic [31:0]                    rdata_reg;
    logic [1:0]                     ref_sync_reg;
    logic                           ref_prev_reg;
    logic                           ref_rise;
    logic [pdc_pkg::LOOP_DIV_W-1:0] in_cnt_reg;
    logic                           ref_div_tick;
    logic [pdc_pkg::PERIOD_W-1:0]   period_cnt_reg;
    logic [pdc_pkg::PERIOD_W-1:0]   period_reg;
    logic [1:0]                     measures_reg;
    pdc_pkg::pdc_loop_state_t       state_reg;
    logic [pdc_pkg::ACC_W-1:0]      acc_reg;
    logic [pdc_pkg::ACC_W-1:0]      acc_sum;
    logic [pdc_pkg::ACC_W-1:0]      fb_step;
    logic                           quarter_tick;
    logic [1:0]                     phase_reg;
    logic [1:0]                     phase_sel;
    logic [3:0]                     phase_level;
    logic [3:0]                     phase_rise;

    // register field slices
    logic [pdc_pkg::OUT_DIV_W-1:0]  sec2_div;
    logic [pdc_pkg::OUT_DIV_W-1:0]  sec1_div;
    logic [pdc_pkg::OUT_DIV_W-1:0]  prim_div;
    logic [pdc_pkg::LOOP_DIV_W-1:0] fb_div;
    logic [pdc_pkg::LOOP_DIV_W-1:0] in_div;

    assign phase_sel = config_reg[pdc_pkg::PHASE_SEL_LSB +: 2];
    assign sec2_div  = config_reg[pdc_pkg::SEC2_DIV_MSB:pdc_pkg::SEC2_DIV_LSB];
    assign sec1_div  = config_reg[pdc_pkg::SEC1_DIV_MSB:pdc_pkg::SEC1_DIV_LSB];
    assign prim_div  = config_reg[pdc_pkg::PRIM_DIV_MSB:pdc_pkg::PRIM_DIV_LSB];
    assign fb_div    = config_reg[pdc_pkg::FB_DIV_MSB:pdc_pkg::FB_DIV_LSB];
    assign in_div    = config_reg[pdc_pkg::IN_DIV_MSB:pdc_pkg::IN_DIV_LSB];

    // register writes
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            config_reg <= pdc_pkg::CONFIG_RESET;
        end else if (reg_write_i && reg_addr_i == pdc_pkg::CONFIG_OFFSET) begin
            config_reg <= reg_wdata_i;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= '0;
        end else if (!reg_read_i) begin
            rdata_reg <= '0;
        end else if (reg_addr_i == pdc_pkg::CONFIG_OFFSET) begin
            rdata_reg <= config_reg;
        end else if (reg_addr_i == pdc_pkg::STATUS_OFFSET) begin
            rdata_reg <= '0;
            rdata_reg[pdc_pkg::STATUS_LOCK_BIT] <= loop_locked_o;
            rdata_reg[pdc_pkg::PERIOD_W-1:0]    <= period_reg;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // the reference may come from a pad or from core routing, so resync it
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ref_sync_reg <= '0;
            ref_prev_reg <= 1'b0;
        end else begin
            ref_sync_reg <= {ref_sync_reg[0], reference_clock_in_i};
            ref_prev_reg <= ref_sync_reg[1];
        end
    end

    assign ref_rise = ref_sync_reg[1] && !ref_prev_reg;

    // input divider n
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            in_cnt_reg <= '0;
        end else if (ref_rise) begin
            if (in_cnt_reg >= in_div) begin
                in_cnt_reg <= '0;
            end else begin
                in_cnt_reg <= in_cnt_reg + 7'h01;
            end
        end
    end

    assign ref_div_tick = ref_rise && (in_cnt_reg >= in_div);

    // period of the divided reference in system cycles
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            period_cnt_reg <= '0;
            period_reg     <= '0;
        end else if (ref_div_tick) begin
            period_cnt_reg <= 16'h0001;
            period_reg     <= period_cnt_reg;
        end else if (period_cnt_reg != '1) begin
            period_cnt_reg <= period_cnt_reg + 16'h0001;
        end
    end

    // lock sequencing: the loop runs once two full periods have been measured
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg    <= pdc_pkg::PDC_HUNT;
            measures_reg <= '0;
        end else begin
            case (state_reg)
                pdc_pkg::PDC_HUNT: begin
                    measures_reg <= '0;
                    if (ref_div_tick) begin
                        state_reg <= pdc_pkg::PDC_MEASURE;
                    end
                end
                pdc_pkg::PDC_MEASURE: begin
                    if (period_cnt_reg == '1) begin
                        state_reg <= pdc_pkg::PDC_HUNT;
                    end else if (ref_div_tick) begin
                        measures_reg <= measures_reg + 2'h1;
                        if (measures_reg + 2'h1 >= pdc_pkg::LOCK_MEASURES) begin
                            state_reg <= pdc_pkg::PDC_RUN;
                        end
                    end
                end
                pdc_pkg::PDC_RUN: begin
                    // a stopped reference drops lock
                    if (period_cnt_reg == '1) begin
                        state_reg <= pdc_pkg::PDC_HUNT;
                    end
                end
                default: begin
                    state_reg <= pdc_pkg::PDC_HUNT;
                end
            endcase
        end
    end

    assign loop_locked_o = (state_reg == pdc_pkg::PDC_RUN);

    // oscillator: 4*m quarter steps per divided reference period
    assign fb_step = {{(pdc_pkg::ACC_W-pdc_pkg::LOOP_DIV_W-3){1'b0}},
                      ({1'b0, fb_div} + 8'h01), 2'b00};
    assign acc_sum = acc_reg + fb_step;
    assign quarter_tick = loop_locked_o &&
                          (acc_sum >= {2'b00, period_reg});

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            acc_reg <= '0;
        end else if (!loop_locked_o) begin
            acc_reg <= '0;
        end else if (quarter_tick) begin
            acc_reg <= acc_sum - {2'b00, period_reg};
        end else begin
            acc_reg <= acc_sum;
        end
    end

    // one phase counter feeds every output so edges stay related
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            phase_reg <= '0;
        end else if (quarter_tick) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // phase k is high for two quarters starting at quarter k
    always_comb begin
        for (int k = 0; k < pdc_pkg::PHASE_COUNT; k++) begin
            phase_level[k] = ((phase_reg - 2'(k)) < 2'h2);
            phase_rise[k]  = quarter_tick && ((phase_reg + 2'h1) == 2'(k));
        end
    end

    pdc_out_div u_primary_div (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .edge_i    (phase_rise[phase_sel]),
        .level_i   (phase_level[phase_sel]),
        .ratio_i   (prim_div),
        .clk_o     (primary_global_clock_o)
    );

    pdc_out_div u_first_secondary_div (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .edge_i    (phase_rise[0]),
        .level_i   (phase_level[0]),
        .ratio_i   (sec1_div),
        .clk_o     (first_secondary_global_clock_o)
    );

    pdc_out_div u_second_secondary_div (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .edge_i    (phase_rise[0]),
        .level_i   (phase_level[0]),
        .ratio_i   (sec2_div),
        .clk_o     (second_secondary_global_clock_o)
    );

    // core copies share the global flop, so frequency and phase match
    assign first_secondary_core_clock_o  = first_secondary_global_clock_o;
    assign second_secondary_core_clock_o = second_secondary_global_clock_o;

endmodule : pdc_pll_divider_config

// File: tb/pdc_pll_divider_config_assertions.sv
// checker for the conditioner register port and clock outputs
module pdc_checker (
    // clock and reset
    input wire logic                       clk_sys_i,
    input wire logic                       reset_i,
    // register port
    input wire logic [pdc_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0]                reg_wdata_i,
    input wire logic                       reg_write_i,
    input wire logic                       reg_read_i,
    input wire logic [31:0]                reg_rdata_o,
    // clocks and status
    input wire logic                       first_secondary_global_clock_o,
    input wire logic                       first_secondary_core_clock_o,
    input wire logic                       second_secondary_global_clock_o,
    input wire logic                       second_secondary_core_clock_o,
    input wire logic                       loop_locked_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic [31:0] cfg_reg;
    logic        rd_cfg;
    logic        rd_sts;
    assign rd_cfg = reg_read_i && reg_addr_i == pdc_pkg::CONFIG_OFFSET;
    assign rd_sts = reg_read_i && reg_addr_i == pdc_pkg::STATUS_OFFSET;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_reg <= pdc_pkg::CONFIG_RESET;
        end else if (reg_write_i && reg_addr_i == pdc_pkg::CONFIG_OFFSET) begin
            cfg_reg <= reg_wdata_i;
        end
    end
    property p_cfg_read; rd_cfg |=> reg_rdata_o == $past(cfg_reg); endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config read back differs from last write");
    property p_sts_read;
        rd_sts |=> reg_rdata_o[31] == $past(loop_locked_o)
            && reg_rdata_o[30:16] == 15'h0;
    endproperty
    a_sts_read: assert property (p_sts_read)
        else $error("status word wrong");
    property p_bad_read;
        reg_read_i && !rd_cfg && !rd_sts |=> reg_rdata_o == 32'h0;
    endproperty
    a_bad_read: assert property (p_bad_read)
        else $error("unmapped read not zero");
    property p_idle_rdata; !reg_read_i |=> reg_rdata_o == 32'h0; endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data outside read cycle");
    property p_sec1_pair;
        first_secondary_core_clock_o == first_secondary_global_clock_o;
    endproperty
    a_sec1_pair: assert property (p_sec1_pair)
        else $error("first secondary copies differ");
    property p_sec2_pair;
        second_secondary_core_clock_o == second_secondary_global_clock_o;
    endproperty
    a_sec2_pair: assert property (p_sec2_pair)
        else $error("second secondary copies differ");
    // with the oscillator stopped neither secondary global output may move
    property p_sec1_idle;
        !loop_locked_o [*6] |-> $stable(first_secondary_global_clock_o);
    endproperty
    a_sec1_idle: assert property (p_sec1_idle)
        else $error("first secondary moves without oscillator");
    property p_sec2_idle;
        !loop_locked_o [*6] |-> $stable(second_secondary_global_clock_o);
    endproperty
    a_sec2_idle: assert property (p_sec2_idle)
        else $error("second secondary moves without oscillator");
endmodule : pdc_checker

bind pdc_pll_divider_config pdc_checker pdc_checker_i (.clk_sys_i, .reset_i,
    .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
    .first_secondary_global_clock_o, .first_secondary_core_clock_o,
    .second_secondary_global_clock_o, .second_secondary_core_clock_o,
    .loop_locked_o);

// File: tb/pdc_ref_source.sv
// reference clock source standing at the conditioner reference pin
module pdc_ref_source (
    // half period in ns
    input  wire logic [15:0] half_ns_i,
    // reference clock as from a pad
    output logic             ref_clk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // offset keeps reference edges clear of system clock edges
    initial begin
        ref_clk_o = 1'b0;
        #1.3;
        forever begin
            #(half_ns_i);
            ref_clk_o = ~ref_clk_o;
        end
    end
endmodule : pdc_ref_source

// File: tb/pdc_pll_divider_config_test.sv
// self-checking bench for the pll divider configuration block
`define CHK(what, exp, got) \
    tests_run++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end
module pdc_pll_divider_config_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WIN = 4000;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        ref_clk;
    logic [15:0] half_ns = 16'h0050;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        write = 1'b0;
    logic        read = 1'b0;
    logic [31:0] rdata;
    logic        prim;
    logic        s1g;
    logic        s2g;
    logic        s1c;
    logic        chain;
    logic        locked;
    int          num_errors = 0;
    int          tests_run = 0;
    pdc_ref_source pdc_ref_source_i (.half_ns_i(half_ns), .ref_clk_o(ref_clk));
    pdc_pll_divider_config pdc_pll_divider_config_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reference_clock_in_i(ref_clk), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(write), .reg_read_i(read),
        .reg_rdata_o(rdata), .primary_global_clock_o(prim),
        .first_secondary_global_clock_o(s1g),
        .first_secondary_core_clock_o(s1c),
        .second_secondary_global_clock_o(s2g),
        .second_secondary_core_clock_o(), .loop_locked_o(locked));
    // second stage of a chain, left at its reset ratios of one
    pdc_pll_divider_config pdc_pll_divider_config_chain_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reference_clock_in_i(s1c),
        .reg_addr_i(8'h00), .reg_wdata_i(32'h0),
        .reg_write_i(1'b0), .reg_read_i(1'b0), .reg_rdata_o(),
        .primary_global_clock_o(chain),
        .first_secondary_global_clock_o(),
        .first_secondary_core_clock_o(),
        .second_secondary_global_clock_o(),
        .second_secondary_core_clock_o(), .loop_locked_o());
    initial begin
        forever begin
            #2;
            clk_sys_i = ~clk_sys_i;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clk_sys_i);
        write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        read <= 1'b1;
        @(posedge clk_sys_i);
        read <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    function automatic int near(input int e, input int g);
        return (e - g <= 2 && g - e <= 2) ? e : g;
    endfunction : near
    // edge counts over a window, tolerant of the window's ragged ends
    task automatic run_cfg(input logic [31:0] cfg, input logic [15:0] per,
                           input int ep, input int e1, input int e2);
        logic [31:0] d;
        logic [3:0]  prev;
        int          n [4];
        int          k;
        wr(pdc_pkg::CONFIG_OFFSET, cfg);
        repeat (1000) @(posedge clk_sys_i);
        k = 0;
        while (locked !== 1'b1 && k < 5000) begin
            @(posedge clk_sys_i);
            k++;
        end
        rd(pdc_pkg::STATUS_OFFSET, d);
        `CHK("lock", 1'b1, d[31])
        `CHK("period", per, d[15:0])
        n = '{0, 0, 0, 0};
        prev = {prim, s1g, s2g, chain};
        repeat (WIN) begin
            @(posedge clk_sys_i);
            n[0] += int'(prim && !prev[3]);
            n[1] += int'(s1g && !prev[2]);
            n[2] += int'(s2g && !prev[1]);
            n[3] += int'(chain && !prev[0]);
            prev = {prim, s1g, s2g, chain};
        end
        `CHK("chained primary edges", e1, near(e1, n[3]))
        `CHK("primary edges", ep, near(ep, n[0]))
        `CHK("first secondary edges", e1, near(e1, n[1]))
        `CHK("second secondary edges", e2, near(e2, n[2]))
    endtask : run_cfg
    // cycles from a phase 0 rise to the next primary rise, both undivided
    task automatic phase_lag(input logic [31:0] cfg, input int lag);
        logic pp;
        logic p1;
        int   k;
        int   seen;
        wr(pdc_pkg::CONFIG_OFFSET, cfg);
        repeat (200) @(posedge clk_sys_i);
        k = -1;
        seen = -1;
        pp = prim;
        p1 = s1g;
        repeat (40) begin
            @(posedge clk_sys_i);
            if (s1g && !p1 && k < 0) begin
                k = 0;
            end
            if (prim && !pp && k >= 0 && seen < 0) begin
                seen = k;
            end
            if (k >= 0) begin
                k++;
            end
            pp = prim;
            p1 = s1g;
        end
        `CHK("phase lag", 1'b1, seen >= lag && seen <= lag + 1)
    endtask : phase_lag
    task automatic t_reset();
        logic [31:0] d;
        rd(pdc_pkg::CONFIG_OFFSET, d);
        `CHK("config reset", pdc_pkg::CONFIG_RESET, d)
        rd(8'h08, d);
        `CHK("unmapped read", 32'h0, d)
        $display("test reset done");
    endtask : t_reset
    task automatic t_phase();
        for (int ps = 0; ps < 4; ps++) begin
            run_cfg(32'h0418_4180 | (ps << 29), 16'h0028, 200, 100, 80);
            phase_lag(32'h0400_0180 | (ps << 29), ps * 5 / 2);
        end
        $display("test phase select done");
    endtask : t_phase
    task automatic t_in_div();
        run_cfg(32'h0308_0381, 16'h0050, 400, 200, 100);
        $display("test input divider done");
    endtask : t_in_div
    task automatic t_fields();
        logic [31:0] d;
        wr(pdc_pkg::CONFIG_OFFSET, 32'hffff_ffff);
        wr(8'h08, 32'h0);
        wr(pdc_pkg::STATUS_OFFSET, 32'h0);
        rd(pdc_pkg::CONFIG_OFFSET, d);
        `CHK("config max fields", 32'hffff_ffff, d)
        $display("test fields done");
    endtask : t_fields
    task automatic end_of_test();
        $display("tests run %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200us;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        t_reset();
        t_phase();
        t_in_div();
        t_fields();
        end_of_test();
    end
endmodule : pdc_pll_divider_config_test
